// [rtl/sctp_pkg.sv]
// Purpose: constants for the six-channel timer pwm block
// Assumes: axi4-lite, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
package sctp_pkg;
    localparam int unsigned sctp_channels = 6;
    localparam int unsigned sctp_count_width = 16;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] sctp_off_status = 8'h00;
    localparam logic [7:0] sctp_off_modulo = 8'h04;
    localparam logic [7:0] sctp_off_count = 8'h08;
    localparam logic [7:0] sctp_off_ch_ctrl = 8'h10;
    localparam logic [7:0] sctp_off_ch_cmp = 8'h30;
    // ------------------------------------------------------------
    // timer status/control fields
    // ------------------------------------------------------------
    localparam int unsigned sctp_bit_ovf = 7;
    localparam int unsigned sctp_bit_ovf_ie = 6;
    localparam int unsigned sctp_bit_halt = 5;
    localparam int unsigned sctp_bit_trst = 4;
    localparam int unsigned sctp_ps_lsb = 0;
    localparam logic [2:0] sctp_ps_external = 3'h7;
    // ------------------------------------------------------------
    // channel status/control fields
    // ------------------------------------------------------------
    localparam int unsigned sctp_bit_chf = 7;
    localparam int unsigned sctp_bit_chie = 6;
    localparam int unsigned sctp_bit_msb = 5;
    localparam int unsigned sctp_bit_msa = 4;
    localparam int unsigned sctp_bit_elsb = 3;
    localparam int unsigned sctp_bit_elsa = 2;
    localparam int unsigned sctp_bit_tov = 1;
    localparam int unsigned sctp_bit_max = 0;
    // ------------------------------------------------------------
    // reset values and bus response codes
    // ------------------------------------------------------------
    localparam logic [7:0] sctp_status_reset = 8'h20;
    localparam logic [15:0] sctp_modulo_reset = 16'hFFFF;
    localparam logic [1:0] sctp_resp_okay = 2'h0;
    localparam logic [1:0] sctp_resp_slverr = 2'h2;
endpackage : sctp_pkg

// [rtl/sctp_prescaler.sv]
// Purpose: counter tick source for the pwm timer
// Assumes: external clock pin already synchronous to aclk
// Notes: rising edge of the external pin makes one tick
`timescale 1ns/1ps
module sctp_prescaler (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic run,
    input wire logic [2:0] prescale_select,
    input wire logic ext_clock,
    output logic tick
);
    logic [5:0] div;
    logic ext_last;
    logic [5:0] mask;
    logic div_hit;

    // divide by 2^code: tick when the low code bits of div are all one
    assign mask = 6'(({6'h0, 1'b1} << prescale_select) - 7'h01);
    assign div_hit = ((div & mask) == mask);

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            div <= 6'h00;
            ext_last <= 1'b0;
            tick <= 1'b0;
        end else begin
            ext_last <= ext_clock;
            if (!run) begin
                tick <= 1'b0;
            end else if (prescale_select == sctp_pkg::sctp_ps_external) begin
                tick <= ext_clock && !ext_last;
            end else begin
                div <= div + 6'h01;
                tick <= div_hit;
            end
        end
    end
endmodule : sctp_prescaler

// [rtl/sctp_timer.sv]
// Purpose: six-channel 16-bit pwm timer with axi4-lite registers
// Assumes: one clock, synchronous active-low reset
// Notes: input capture and the counter read latch are not built
`timescale 1ns/1ps
module sctp_timer #(
    parameter int unsigned channels = sctp_pkg::sctp_channels
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clock,
    output logic [5:0] channel_pin,
    output logic [5:0] channel_pin_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] count;
    logic [15:0] modulo;
    logic overflow_flag;
    logic overflow_ie;
    logic counter_halt_bit;
    logic [2:0] prescale_select;
    logic trst_pulse;
    logic ovf_armed;
    logic [7:0] chan_ctrl [6];
    logic [15:0] chan_cmp [6];
    logic [2:0] pair_active;
    logic [2:0] pair_pending;
    logic [2:0] pair_written_odd;
    logic [5:0] pin_level;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic tick;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic [3:0] sctp_chan_index(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] rel;
        rel = addr - base;
        return (addr >= base && rel[7:2] < 6'd6 && rel[1:0] == 2'b00) ? {1'b0, rel[4:2]} : 4'hF;
    endfunction : sctp_chan_index

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [3:0] w_ctrl_idx = sctp_chan_index(aw_addr, sctp_pkg::sctp_off_ch_ctrl);
    wire [3:0] w_cmp_idx = sctp_chan_index(aw_addr, sctp_pkg::sctp_off_ch_cmp);
    wire [3:0] r_ctrl_idx = sctp_chan_index(s_axi_araddr, sctp_pkg::sctp_off_ch_ctrl);
    wire [3:0] r_cmp_idx = sctp_chan_index(s_axi_araddr, sctp_pkg::sctp_off_ch_cmp);
    wire w_status = do_write && aw_addr == sctp_pkg::sctp_off_status && w_strb[0];
    wire w_modulo = do_write && aw_addr == sctp_pkg::sctp_off_modulo;
    wire w_hit = aw_addr == sctp_pkg::sctp_off_status || aw_addr == sctp_pkg::sctp_off_modulo
        || aw_addr == sctp_pkg::sctp_off_count || w_ctrl_idx != 4'hF || w_cmp_idx != 4'hF;
    wire r_hit = s_axi_araddr == sctp_pkg::sctp_off_status
        || s_axi_araddr == sctp_pkg::sctp_off_modulo || s_axi_araddr == sctp_pkg::sctp_off_count
        || r_ctrl_idx != 4'hF || r_cmp_idx != 4'hF;
    wire overflow = tick && count == modulo;
    wire [15:0] count_next = overflow ? 16'h0000 : 16'(count + 16'h0001);
    wire [7:0] status_view = {overflow_flag, overflow_ie, counter_halt_bit, 1'b0, 1'b0,
        prescale_select};

    // ------------------------------------------------------------
    // prescaler and counter
    // ------------------------------------------------------------
    sctp_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(trst_pulse),
        .run(!counter_halt_bit),
        .prescale_select(prescale_select),
        .ext_clock(ext_clock),
        .tick(tick)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn || trst_pulse) begin
            count <= 16'h0000;
        end else if (tick) begin
            count <= count_next;
        end
    end

    // ------------------------------------------------------------
    // timer status/control
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag <= 1'b0;
            overflow_ie <= 1'b0;
            counter_halt_bit <= sctp_pkg::sctp_status_reset[sctp_pkg::sctp_bit_halt];
            prescale_select <= 3'h0;
            trst_pulse <= 1'b0;
            ovf_armed <= 1'b0;
        end else begin
            // reset bit is a one-cycle strobe, never stored for readback
            trst_pulse <= w_status && w_data[sctp_pkg::sctp_bit_trst];
            if (do_read && s_axi_araddr == sctp_pkg::sctp_off_status && overflow_flag) begin
                ovf_armed <= 1'b1;
            end
            if (overflow) begin
                overflow_flag <= 1'b1;
                ovf_armed <= 1'b0;
            end else if (w_status && !w_data[sctp_pkg::sctp_bit_ovf] && ovf_armed) begin
                overflow_flag <= 1'b0;
                ovf_armed <= 1'b0;
            end
            if (w_status) begin
                overflow_ie <= w_data[sctp_pkg::sctp_bit_ovf_ie];
                counter_halt_bit <= w_data[sctp_pkg::sctp_bit_halt];
                prescale_select <= w_data[2:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modulo <= sctp_pkg::sctp_modulo_reset;
        end else if (w_modulo) begin
            modulo <= w_data[15:0];
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_chan
            localparam int unsigned pair = gi / 2;
            localparam bit is_even = (gi % 2) == 0;
            logic [7:0] ctrl;
            logic linked;
            logic slave;
            logic [15:0] active_cmp;
            logic match;
            logic set_pin;
            logic pwm_on;
            assign ctrl = chan_ctrl[gi];
            // upper mode bit wins regardless of the lower one
            assign linked = is_even && chan_ctrl[pair * 2][sctp_pkg::sctp_bit_msb];
            assign slave = !is_even && chan_ctrl[pair * 2][sctp_pkg::sctp_bit_msb];
            assign active_cmp = (linked && pair_active[pair]) ? chan_cmp[pair * 2 + 1]
                : chan_cmp[gi];
            // compare uses the live register, so a late write can skip a period
            // match on the tick that brings the counter to the value: width = compare steps
            assign match = tick && count_next == active_cmp;
            assign set_pin = ctrl[sctp_pkg::sctp_bit_elsa];
            assign pwm_on = ctrl[sctp_pkg::sctp_bit_elsb] && !slave
                && (ctrl[sctp_pkg::sctp_bit_msb] || ctrl[sctp_pkg::sctp_bit_msa]);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_level[gi] <= 1'b0;
                    channel_pin_oe[gi] <= 1'b0;
                    chan_ctrl[gi] <= 8'h00;
                    chan_cmp[gi] <= 16'h0000;
                end else begin
                    channel_pin_oe[gi] <= pwm_on;
                    if (pwm_on && ctrl[sctp_pkg::sctp_bit_max]
                            && ctrl[sctp_pkg::sctp_bit_tov]) begin
                        pin_level[gi] <= !set_pin;
                    end else if (pwm_on && match) begin
                        pin_level[gi] <= set_pin;
                    end else if (pwm_on && overflow && ctrl[sctp_pkg::sctp_bit_tov]) begin
                        pin_level[gi] <= !pin_level[gi];
                    end
                    if (do_write && w_cmp_idx == 4'(gi)) begin
                        chan_cmp[gi] <= w_data[15:0];
                    end
                    if (do_write && w_ctrl_idx == 4'(gi) && w_strb[0]) begin
                        chan_ctrl[gi][6:0] <= w_data[6:0];
                        if (!w_data[sctp_pkg::sctp_bit_chf]) begin
                            chan_ctrl[gi][sctp_pkg::sctp_bit_chf] <= 1'b0;
                        end
                    end
                    if (match && !slave) begin
                        chan_ctrl[gi][sctp_pkg::sctp_bit_chf] <= 1'b1;
                    end
                end
            end
        end

        for (gi = 0; gi < 3; gi++) begin : g_pair
            always_ff @(posedge aclk) begin
                if (!aresetn || !chan_ctrl[gi * 2][sctp_pkg::sctp_bit_msb]) begin
                    pair_active[gi] <= 1'b0;
                    pair_pending[gi] <= 1'b0;
                    pair_written_odd[gi] <= 1'b0;
                end else begin
                    if (do_write && w_cmp_idx == 4'(gi * 2 + 1)) begin
                        pair_written_odd[gi] <= 1'b1;
                        pair_pending[gi] <= 1'b1;
                    end else if (do_write && w_cmp_idx == 4'(gi * 2)) begin
                        pair_written_odd[gi] <= 1'b0;
                        pair_pending[gi] <= 1'b1;
                    end
                    if (overflow && pair_pending[gi]) begin
                        pair_active[gi] <= pair_written_odd[gi];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_pin <= 6'h00;
        end else begin
            channel_pin <= pin_level;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sctp_pkg::sctp_resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? sctp_pkg::sctp_resp_okay : sctp_pkg::sctp_resp_slverr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sctp_pkg::sctp_resp_okay;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= r_hit ? sctp_pkg::sctp_resp_okay : sctp_pkg::sctp_resp_slverr;
            if (s_axi_araddr == sctp_pkg::sctp_off_status) begin
                s_axi_rdata <= {24'h00_0000, status_view};
            end else if (s_axi_araddr == sctp_pkg::sctp_off_modulo) begin
                s_axi_rdata <= {16'h0000, modulo};
            end else if (s_axi_araddr == sctp_pkg::sctp_off_count) begin
                s_axi_rdata <= {16'h0000, count};
            end else if (r_ctrl_idx != 4'hF) begin
                s_axi_rdata <= {24'h00_0000, chan_ctrl[r_ctrl_idx[2:0]]};
            end else if (r_cmp_idx != 4'hF) begin
                s_axi_rdata <= {16'h0000, chan_cmp[r_cmp_idx[2:0]]};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : sctp_timer

// [test/sctp_timer_props.sv]
// Purpose: port-level checks of the timer pwm register bus
// Assumes: one clock, synchronous active-low reset
// Notes: pin timing is judged by the bench through the load model
`timescale 1ns/1ps
module sctp_timer_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] channel_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel open while a response is pending");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while read data is pending");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before bready");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    chk_write_latency: assert property (both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not two edges after the write was taken");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one edge after the address was taken");
    chk_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("write response code out of range");
    chk_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0
        || (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000))
        else $error("bad read response or data with an error response");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half of a register read is not zero");
    cov_write: cover property (both_taken);
    cov_read: cover property (s_axi_arvalid && s_axi_arready);
    cov_pin_rise: cover property ($rose(channel_pin[0]));
    cov_pin_fall: cover property ($fell(channel_pin[4]));
endmodule : sctp_timer_props

bind sctp_timer sctp_timer_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .channel_pin(channel_pin));

// [test/sctp_load_model.sv]
// Purpose: load on the channel pins, measures period and high time
// Assumes: one pin is watched at a time, chosen by sel
// Notes: first values after a change of sel are meaningless
`timescale 1ns/1ps
module sctp_load_model (
    input wire logic aclk,
    input wire logic [5:0] pin,
    input wire logic [5:0] oe,
    input wire logic [2:0] sel,
    output logic level,
    output logic [31:0] rises = 32'h0000_0000,
    output logic [31:0] period_len = 32'h0000_0000,
    output logic [31:0] high_len = 32'h0000_0000
);
    logic [31:0] cyc = 32'h0000_0000;
    logic [31:0] last_rise = 32'h0000_0000;
    logic prev = 1'b0;
    // a released pin is pulled low by the load, so it never shows a stale level
    assign level = oe[sel] ? pin[sel] : 1'b0;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        prev <= level;
        if (level && !prev) begin
            rises <= rises + 1;
            period_len <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (!level && prev) begin
            high_len <= cyc - last_rise;
        end
    end
endmodule : sctp_load_model

// [test/test_six_channel_timer_pwm.sv]
// Purpose: self-checking bench of the timer pwm block over axi4-lite
// Assumes: pin waveforms are measured by the load model
// Notes: every expected period and high time is worked out from modulo, compare and prescale, or from the external clock rate for code 7
`timescale 1ns/1ps
module test_six_channel_timer_pwm;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic ext_clock = 1'b0;
    logic [2:0] ext_div = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, level;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rv, rises, period_len, high_len, r_base;
    logic [5:0] pin, oe;
    logic [2:0] sel = 3'h0;
    int err_total = 0;
    int checks = 0;

    initial begin
        forever #10 aclk = ~aclk;
    end
    // external counter clock: one rising edge every eight bus clocks
    always @(posedge aclk) begin
        ext_div <= ext_div + 3'h1;
        ext_clock <= ext_div[2];
    end

    sctp_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_clock(ext_clock), .channel_pin(pin), .channel_pin_oe(oe));
    sctp_load_model u_load (.aclk(aclk), .pin(pin), .oe(oe), .sel(sel), .level(level),
        .rises(rises), .period_len(period_len), .high_len(high_len));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // handshakes are judged on values settled before the taking edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_go = 1'b0;
        while (!b_go) begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid && bready;
            rs = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            if (b_go) bready <= 1'b0;
        end
    endtask : wr

    task rd(input logic [7:0] a);
        logic ar_go, r_go;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_go = 1'b0;
        while (!r_go) begin
            @(negedge aclk);
            ar_go = arvalid && arready;
            r_go = rvalid && rready;
            rv = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
            if (r_go) rready <= 1'b0;
        end
    endtask : rd

    // stop and reset, program period and width, set mode, then release
    task setup(input int ch, input logic [15:0] md, input logic [15:0] cmp,
               input logic [7:0] ctl, input logic [2:0] ps);
        wr(8'h00, 32'h0000_0030 | 32'(ps));
        wr(8'h04, {16'h0000, md});
        wr(8'h30 + 8'(4 * ch), {16'h0000, cmp});
        wr(8'h10 + 8'(4 * ch), {24'h00_0000, ctl});
        wr(8'h00, 32'(ps));
    endtask : setup

    // the third rise guarantees one whole period and one whole pulse were seen
    task measure(input int ch, input int per, input int hi);
        int r0;
        sel <= 3'(ch);
        r0 = rises;
        while (rises < r0 + 3) @(posedge aclk);
        chk(period_len, 32'(per));
        chk(high_len, 32'(hi));
    endtask : measure

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00);
        chk(rv, 32'h0000_0020);
        rd(8'h04);
        chk(rv, 32'h0000_ffff);
        rd(8'hfc);
        chk(32'(rs), 32'h0000_0002);
        wr(8'hfc, 32'h0000_1234);
        chk(32'(rs), 32'h0000_0002);
        $display("test registers done");
        setup(0, 16'h00ff, 16'h0080, 8'h1a, 3'h0);
        measure(0, 256, 128);
        @(negedge level);
        wr(8'h30, 32'h0000_0040);
        measure(0, 256, 64);
        @(posedge level);
        wr(8'h30, 32'h0000_0080);
        measure(0, 256, 128);
        $display("test unbuffered done");
        for (int k = 0; k < 7; k++) begin
            setup(3, 16'h0003, 16'h0001, 8'h1a, 3'(k));
            measure(3, 4 << k, 1 << k);
        end
        setup(3, 16'h0003, 16'h0001, 8'h1a, 3'h7);
        measure(3, 32, 8);
        rd(8'h1c);
        chk(32'(rv[7]), 32'h0000_0001);
        setup(3, 16'h000f, 16'h0004, 8'h1e, 3'h0);
        measure(3, 16, 12);
        $display("test prescale and polarity done");
        setup(3, 16'h0003, 16'h0001, 8'h18, 3'h0);
        repeat (20) @(posedge aclk);
        r_base = rises;
        repeat (100) @(posedge aclk);
        chk(rises, r_base);
        chk(32'(level), 32'h0000_0000);
        setup(3, 16'h0003, 16'h0001, 8'h1b, 3'h0);
        repeat (20) @(posedge aclk);
        r_base = rises;
        repeat (100) @(posedge aclk);
        chk(rises, r_base);
        chk(32'(level), 32'h0000_0001);
        $display("test duty limits done");
        for (int p = 0; p < 6; p += 2) begin
            wr(8'h14 + 8'(4 * p), 32'h0000_001a);
            setup(p, 16'h00ff, 16'h0040, 8'h3a, 3'h0);
            measure(p, 256, 64);
            chk(32'(oe[p + 1]), 32'h0000_0000);
            wr(8'h34 + 8'(4 * p), 32'h0000_0020);
            measure(p, 256, 32);
        end
        $display("test buffered done");
        wr(8'h00, 32'h0000_0020);
        rd(8'h00);
        chk(rv, 32'h0000_00a0);
        wr(8'h00, 32'h0000_0020);
        rd(8'h00);
        chk(rv, 32'h0000_0020);
        wr(8'h00, 32'h0000_0000);
        repeat (300) @(posedge aclk);
        rd(8'h00);
        repeat (300) @(posedge aclk);
        wr(8'h00, 32'h0000_0020);
        rd(8'h00);
        chk(rv, 32'h0000_00a0);
        wr(8'h00, 32'h0000_0030);
        rd(8'h00);
        chk(32'(rv[4]), 32'h0000_0000);
        rd(8'h08);
        chk(rv, 32'h0000_0000);
        $display("test status done");
        stop_test();
    end

    initial begin
        repeat (50000) @(posedge aclk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule : test_six_channel_timer_pwm
